// *** pkg/clkpg_pkg.sv ***
// Purpose : Shared constants for the clock pulse generator block
// Assumes : 200 MHz system clock; one PLL stage-1 output cycle is two system cycles
// Notes   : Register offsets are byte addresses on the plain register port

package clkpg_pkg;

	// ==========================================================
	// Register port geometry
	localparam int unsigned ADDR_W = 4;  // Byte address width
	localparam int unsigned DATA_W = 32; // Data width

	// ==========================================================
	// Register offsets
	localparam logic [3:0] OFF_FREQ  = 4'h0; // Frequency control register
	localparam logic [3:0] OFF_PWR   = 4'h4; // Sleep / standby / pin control
	localparam logic [3:0] OFF_MSTOP = 4'h8; // Module clock stop bits
	localparam logic [3:0] OFF_STAT  = 4'hC; // Read-only status

	// ==========================================================
	// Frequency control register fields
	localparam int unsigned FRQ_PDIV_LSB = 0;  // Peripheral divider select, 2 bits
	localparam int unsigned FRQ_IDIV_LSB = 4;  // Internal divider select, 2 bits
	localparam int unsigned FRQ_MUL1_LSB = 8;  // Stage-1 multiplier select, 2 bits
	localparam int unsigned FRQ_STBO_BIT = 12; // Drive bus clock pin in standby
	localparam logic [15:0] FRQ_RESET    = 16'h1000; // Ratios x1, bus out in standby
	localparam logic [15:0] FRQ_WMASK    = 16'h1333; // Implemented bits

	// ==========================================================
	// Power control register fields
	localparam int unsigned PWR_SLEEP_BIT = 0; // Stop internal clock
	localparam int unsigned PWR_STBY_BIT  = 1; // Stop internal and peripheral clocks; bus clock too unless FRQ_STBO_BIT is set
	localparam int unsigned PWR_HIZ_BIT   = 2; // Float bus clock pin
	localparam logic [2:0]  PWR_RESET     = 3'h0;

	// ==========================================================
	// Module stop register
	localparam int unsigned NMOD        = 8;     // Peripheral clock branches
	localparam logic [7:0]  MSTOP_RESET = 8'h00; // All modules clocked

	// ==========================================================
	// Status register fields
	localparam int unsigned ST_MODE_LSB = 0; // Decoded mode, 2 bits
	localparam int unsigned ST_BAD_BIT  = 2; // Reserved pin combination seen
	localparam int unsigned ST_REF_BIT  = 3; // Reference edges seen
	localparam int unsigned ST_MUL2_LSB = 4; // Stage-2 factor, 3 bits
	localparam int unsigned ST_MUL1_LSB = 8; // Effective stage-1 factor, 3 bits

	// ==========================================================
	// Clock operating modes, coded as {high pin, low pin}
	typedef enum logic [1:0] {
		CLKPG_MODE2 = 2'b00,
		CLKPG_MODE6 = 2'b10,
		CLKPG_MODE7 = 2'b11
	} clkpg_mode_t;

	// Stage-2 multiplication factors; zero means off
	localparam logic [2:0] MUL2_MODE2 = 3'h4;
	localparam logic [2:0] MUL2_MODE6 = 3'h2;
	localparam logic [2:0] MUL2_OFF   = 3'h0;

	// Largest stage-1 select allowed in mode 2 (x2)
	localparam logic [1:0] MUL1_MAX_MODE2 = 2'h1;

	// Cycles after reset release before the mode pins are taken
	localparam logic [1:0] MODE_SAMPLE_CYC = 2'h3;

endpackage

// *** hw/clkpg_div.sv ***
// Purpose : Glitch-free programmable clock divider producing a square wave
// Assumes : Ratio 1..4; one ratio unit equals two system cycles
// Notes   : A new ratio is only taken at the end of a period or on restart

`timescale 1ns/10ps

module clkpg_div (
	input  wire logic       i_clk_sys, // System clock
	input  wire logic       i_nrst,    // Async reset, active low
	input  wire logic [2:0] i_ratio,   // Division ratio 1..4
	input  wire logic       i_restart, // Restart phase at the bus clock rise
	input  wire logic       i_run,     // Clock runs while high
	output logic            o_clk,     // Divided clock level
	output logic            o_rise     // Pulse with each rising edge
);

	// ==========================================================
	// Phase state
	logic [2:0] ratio_q; // Ratio in use for the current period
	logic [2:0] cnt_q;   // Position inside the period
	logic [2:0] cnt_d;   // Next position
	logic       last;    // Final cycle of the period

	// Period is twice the ratio; last count is 2*ratio-1
	assign last  = (cnt_q == 3'({ratio_q, 1'b0} - 4'h1));
	assign cnt_d = (i_restart || last) ? 3'h0 : 3'(cnt_q + 3'h1);

	// Counter and ratio latch; the ratio never changes mid-period
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_q   <= 3'h0;
			ratio_q <= 3'h1;
		end else begin
			cnt_q <= cnt_d;
			if (i_restart || last) begin
				ratio_q <= i_ratio;
			end
		end
	end

	// Registered outputs so no combinational glitch leaves the block
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_clk  <= 1'b0;
			o_rise <= 1'b0;
		end else begin
			o_clk  <= i_run && (cnt_d < ((i_restart || last) ? i_ratio : ratio_q));
			o_rise <= i_run && (cnt_d == 3'h0);
		end
	end

endmodule // clkpg_div

// *** hw/clkpg_top.sv ***
// Purpose : Clock pulse generator: mode decode, multipliers, dividers, gating
// Assumes : Stage-1 output is modelled as the system clock pair of cycles
// Notes   : Derived clocks are square waves plus one-cycle rise pulses

`timescale 1ns/10ps

module clkpg_top (
	input  wire logic                  i_clk_sys,                        // System clock
	input  wire logic                  i_nrst,                           // Async reset
	// Mode and reference pins
	input  wire logic                  i_clock_mode_pin_low,             // Low mode pin
	input  wire logic                  i_clock_mode_pin_high,            // High mode pin
	input  wire logic                  i_crystal_or_external_clock_input, // Reference
	output logic                       o_crystal_drive_pin,              // Oscillator drive
	// Two-way bus clock pin
	input  wire logic                  i_bus_clock_pin,                  // Pin level in
	output logic                       o_bus_clock_pin,                  // Pin level out
	output logic                       o_bus_clock_pin_oe,               // Pin driven
	// Second clock output pin
	input  wire logic                  i_second_clock_select,            // 1: clock, 0: low
	output logic                       o_second_clock_output_pin,        // Pin level
	output logic                       o_second_clock_output_pin_oe,     // Pin driven
	// Derived clocks
	output logic                       o_clk_int,                        // Internal clock
	output logic                       o_clk_int_rise,                   // Its rise pulse
	output logic                       o_clk_per,                        // Peripheral clock
	output logic                       o_clk_per_rise,                   // Its rise pulse
	output logic                       o_clk_bus,                        // Bus clock
	output logic                       o_clk_bus_rise,                   // Its rise pulse
	output logic [clkpg_pkg::NMOD-1:0] o_clk_mod,                        // Per-module clocks
	// Register port
	input  wire logic [3:0]            i_addr,                           // Byte address
	input  wire logic [31:0]           i_wdata,                          // Write data
	input  wire logic                  i_wr,                             // Write strobe
	input  wire logic                  i_rd,                             // Read strobe
	output logic [31:0]                o_rdata                           // Read data
);

	// ==========================================================
	// Helper functions
	// Field select 0..3 to ratio 1..4, used by every divider
	function automatic logic [2:0] sel_to_ratio(input logic [1:0] sel);
		sel_to_ratio = {1'b0, sel} + 3'h1;
	endfunction

	// Stage-1 select permitted by the mode; mode two caps at x2
	function automatic logic [1:0] mul1_limit(input clkpg_pkg::clkpg_mode_t m,
	                                          input logic [1:0] sel);
		if (m == clkpg_pkg::CLKPG_MODE2 && sel > clkpg_pkg::MUL1_MAX_MODE2) begin
			mul1_limit = clkpg_pkg::MUL1_MAX_MODE2;
		end else begin
			mul1_limit = sel;
		end
	endfunction

	// ==========================================================
	// Pin synchronisers
	// Two flops each; only the second flop is looked at by logic
	logic [3:0] sync1_q; // First stage
	logic [3:0] sync2_q; // Second stage
	logic       md_low;  // Synced low mode pin
	logic       md_high; // Synced high mode pin
	logic       ref_in;  // Synced reference
	logic       pin_in;  // Synced bus clock pin

	// Sample the mode, reference and bus clock pin levels into the system domain
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else begin
			sync1_q <= {i_bus_clock_pin, i_crystal_or_external_clock_input,
			            i_clock_mode_pin_high, i_clock_mode_pin_low};
			sync2_q <= sync1_q;
		end
	end

	assign md_low  = sync2_q[0];
	assign md_high = sync2_q[1];
	assign ref_in  = sync2_q[2];
	assign pin_in  = sync2_q[3];

	// ==========================================================
	// Mode capture after reset release
	clkpg_pkg::clkpg_mode_t mode_q;  // Captured operating mode
	logic [1:0]             wait_q;  // Cycles since release
	logic                   taken_q; // Mode has been taken
	logic                   bad_q;   // Reserved pin combination

	// Pins are static straps: taken once the synchroniser has filled
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			wait_q  <= 2'h0;
			taken_q <= 1'b0;
			mode_q  <= clkpg_pkg::CLKPG_MODE2;
			bad_q   <= 1'b0;
		end else if (!taken_q) begin
			if (wait_q == clkpg_pkg::MODE_SAMPLE_CYC) begin
				taken_q <= 1'b1;
				case ({md_high, md_low})
					2'b00: begin
						mode_q <= clkpg_pkg::CLKPG_MODE2;
					end
					2'b10: begin
						mode_q <= clkpg_pkg::CLKPG_MODE6;
					end
					2'b11: begin
						mode_q <= clkpg_pkg::CLKPG_MODE7;
					end
					default: begin
						// Reserved combination: fall back to mode two, flag it
						mode_q <= clkpg_pkg::CLKPG_MODE2;
						bad_q  <= 1'b1;
					end
				endcase
			end else begin
				wait_q <= 2'(wait_q + 2'h1);
			end
		end
	end

	// Mode seven takes its clock from the pin instead of the reference
	logic ext_mode; // Pin is an input
	assign ext_mode = (mode_q == clkpg_pkg::CLKPG_MODE7);

	// ==========================================================
	// Stage-2 multiplier setting
	logic [2:0] mul2; // Stage-2 factor, zero when off

	// Fixed by mode alone; no register bit reaches it
	always_comb begin
		case (mode_q)
			clkpg_pkg::CLKPG_MODE2: begin
				mul2 = clkpg_pkg::MUL2_MODE2;
			end
			clkpg_pkg::CLKPG_MODE6: begin
				mul2 = clkpg_pkg::MUL2_MODE6;
			end
			default: begin
				mul2 = clkpg_pkg::MUL2_OFF;
			end
		endcase
	end

	// Reference activity: a crude lock indication for software
	logic ref_d1_q; // Delayed reference
	logic ref_ok_q; // Edge seen since reset

	// Watch for reference edges; sticky until reset
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ref_d1_q <= 1'b0;
			ref_ok_q <= 1'b0;
		end else begin
			ref_d1_q <= ref_in;
			if (ref_in && !ref_d1_q) begin
				ref_ok_q <= 1'b1;
			end
		end
	end

	// Oscillator drive is the inverted reference; quiet in mode seven
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_crystal_drive_pin <= 1'b0;
		end else begin
			o_crystal_drive_pin <= !ext_mode && !ref_in;
		end
	end

	// ==========================================================
	// Registers
	logic [15:0]               freq_q;  // Frequency control register
	logic [2:0]                pwr_q;   // Sleep, standby, float
	logic [clkpg_pkg::NMOD-1:0] mstop_q; // Module stop bits

	// Frequency control; stage-1 select clipped to what the mode allows
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			freq_q <= clkpg_pkg::FRQ_RESET;
		end else if (i_wr && i_addr == clkpg_pkg::OFF_FREQ) begin
			freq_q <= i_wdata[15:0] & clkpg_pkg::FRQ_WMASK;
			freq_q[clkpg_pkg::FRQ_MUL1_LSB +: 2] <= mul1_limit(mode_q,
				i_wdata[clkpg_pkg::FRQ_MUL1_LSB +: 2]);
		end
	end

	// Power control
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			pwr_q <= clkpg_pkg::PWR_RESET;
		end else if (i_wr && i_addr == clkpg_pkg::OFF_PWR) begin
			pwr_q <= i_wdata[2:0];
		end
	end

	// Module stop
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			mstop_q <= clkpg_pkg::MSTOP_RESET;
		end else if (i_wr && i_addr == clkpg_pkg::OFF_MSTOP) begin
			mstop_q <= i_wdata[clkpg_pkg::NMOD-1:0];
		end
	end

	// Decoded controls
	logic       sleep;    // Internal clock stopped
	logic       standby;  // Internal and peripheral clocks stopped
	logic       pin_hiz;  // Bus pin floated by software
	logic       stby_out; // Keep bus clock on the pin in standby
	logic [2:0] r_mul1;   // Stage-1 ratio
	logic [2:0] r_int;    // Internal divider ratio
	logic [2:0] r_per;    // Peripheral divider ratio

	assign sleep    = pwr_q[clkpg_pkg::PWR_SLEEP_BIT];
	assign standby  = pwr_q[clkpg_pkg::PWR_STBY_BIT];
	assign pin_hiz  = pwr_q[clkpg_pkg::PWR_HIZ_BIT];
	assign stby_out = freq_q[clkpg_pkg::FRQ_STBO_BIT];
	assign r_mul1   = sel_to_ratio(freq_q[clkpg_pkg::FRQ_MUL1_LSB +: 2]);
	// Software must keep these at or below the stage-1 ratio
	assign r_int    = sel_to_ratio(freq_q[clkpg_pkg::FRQ_IDIV_LSB +: 2]);
	assign r_per    = sel_to_ratio(freq_q[clkpg_pkg::FRQ_PDIV_LSB +: 2]);

	// ==========================================================
	// Bus clock source
	// Internal modes: stage-1 output divided by its ratio gives the bus clock.
	// Mode seven: the synced pin is the bus clock.
	logic gen_bus;      // Generated bus clock
	logic gen_bus_rise; // Its rise pulse
	logic pin_d1_q;     // Delayed synced pin
	logic pin_rise;     // Pin rising edge
	logic bus_rise;     // Bus rising edge from either source
	logic bus_run;      // Bus clock may run

	// Bus clock keeps running in standby only while stby_out is set, which it is from reset
	assign bus_run = taken_q && !ext_mode && (!standby || stby_out);

	clkpg_div u_div_bus (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_ratio   (r_mul1),
		.i_restart (1'b0),
		.i_run     (bus_run),
		.o_clk     (gen_bus),
		.o_rise    (gen_bus_rise)
	);

	// Edge detect on the second synchroniser stage only
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			pin_d1_q <= 1'b0;
		end else begin
			pin_d1_q <= pin_in;
		end
	end

	assign pin_rise = pin_in && !pin_d1_q;
	assign bus_rise = ext_mode ? pin_rise : gen_bus_rise;

	// ==========================================================
	// Internal and peripheral dividers
	// Both restart at each bus rise so their rising edges stay in phase.
	// Ratios not dividing the stage-1 ratio will see a shortened period.
	logic int_raw; // Internal clock before gating
	logic int_rp;  // Its rise pulse
	logic per_raw; // Peripheral clock before gating
	logic per_rp;  // Its rise pulse
	logic int_run; // Internal may run
	logic per_run; // Peripheral may run

	assign int_run = taken_q && !sleep && !standby;
	assign per_run = taken_q && !standby;

	clkpg_div u_div_int (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_ratio   (r_int),
		.i_restart (bus_rise),
		.i_run     (int_run),
		.o_clk     (int_raw),
		.o_rise    (int_rp)
	);

	clkpg_div u_div_per (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_ratio   (r_per),
		.i_restart (bus_rise),
		.i_run     (per_run),
		.o_clk     (per_raw),
		.o_rise    (per_rp)
	);

	// ==========================================================
	// Clock outputs
	assign o_clk_int      = int_raw;
	assign o_clk_int_rise = int_rp;
	assign o_clk_per      = per_raw;
	assign o_clk_per_rise = per_rp;

	// Bus clock: the synced pin in mode seven, the generated clock otherwise
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_clk_bus      <= 1'b0;
			o_clk_bus_rise <= 1'b0;
		end else begin
			o_clk_bus      <= ext_mode ? pin_in : gen_bus;
			o_clk_bus_rise <= bus_rise;
		end
	end

	// Per-module gates; a stopped module sees its clock held low
	genvar gi;
	generate
		for (gi = 0; gi < clkpg_pkg::NMOD; gi++) begin : g_mod
			always_ff @(posedge i_clk_sys or negedge i_nrst) begin
				if (!i_nrst) begin
					o_clk_mod[gi] <= 1'b0;
				end else if (!per_raw) begin
					// Low while per_raw is low; mstop_q is applied in every high cycle, so a stop can cut a pulse short
					o_clk_mod[gi] <= 1'b0;
				end else begin
					o_clk_mod[gi] <= !mstop_q[gi];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Pins
	// Bus pin: drives the bus clock in modes two and six unless floated
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_bus_clock_pin    <= 1'b0;
			o_bus_clock_pin_oe <= 1'b0;
		end else begin
			o_bus_clock_pin    <= gen_bus;
			o_bus_clock_pin_oe <= taken_q && !ext_mode && !pin_hiz;
		end
	end

	// Second output: low or bus clock by selection; floats in mode seven
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_second_clock_output_pin    <= 1'b0;
			o_second_clock_output_pin_oe <= 1'b0;
		end else begin
			o_second_clock_output_pin    <= i_second_clock_select && gen_bus;
			o_second_clock_output_pin_oe <= taken_q && !ext_mode;
		end
	end

	// ==========================================================
	// Read path: data stand in the cycle after the strobe only
	logic [31:0] rd_d; // Selected read word

	always_comb begin
		rd_d = 32'h0000_0000;
		case (i_addr)
			clkpg_pkg::OFF_FREQ: begin
				rd_d[15:0] = freq_q;
			end
			clkpg_pkg::OFF_PWR: begin
				rd_d[2:0] = pwr_q;
			end
			clkpg_pkg::OFF_MSTOP: begin
				rd_d[clkpg_pkg::NMOD-1:0] = mstop_q;
			end
			clkpg_pkg::OFF_STAT: begin
				rd_d[clkpg_pkg::ST_MODE_LSB +: 2] = mode_q;
				rd_d[clkpg_pkg::ST_BAD_BIT]       = bad_q;
				rd_d[clkpg_pkg::ST_REF_BIT]       = ref_ok_q;
				rd_d[clkpg_pkg::ST_MUL2_LSB +: 3] = mul2;
				rd_d[clkpg_pkg::ST_MUL1_LSB +: 3] = r_mul1;
			end
			default: begin
				// Unmapped offsets read as zero
				rd_d = 32'h0000_0000;
			end
		endcase
	end

	// Registered answer; zero when no read was made
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 32'h0000_0000;
		end else begin
			o_rdata <= i_rd ? rd_d : 32'h0000_0000;
		end
	end

endmodule // clkpg_top

// *** dv/clkpg_board.sv ***
// Purpose : Board model: reference source, external bus clock, pin wiring
// Assumes : Free-running sources, unrelated in phase to the system clock
// Notes   : A released pin carries the external clock, never a stale level
`timescale 1ns/10ps

module clkpg_board (
	input  wire logic i_pin_out, // Device level on the bus clock pin
	input  wire logic i_pin_oe,  // Device drives the pin
	output logic      o_ref,     // Crystal or external reference
	output logic      o_pin      // Resolved pin level
);
	logic ext_q; // External bus clock source

	// ==========================================================
	// Reference at 12.5 MHz, inside the range of every mode
	initial begin
		o_ref = 1'b0;
		forever #40 o_ref = ~o_ref;
	end

	// External clock at 25 MHz; it keeps toggling so a float is never read as a level
	initial begin
		ext_q = 1'b0;
		forever #20 ext_q = ~ext_q;
	end

	// Wire resolution: the device wins while it drives
	assign o_pin = i_pin_oe ? i_pin_out : ext_q;
endmodule // clkpg_board

// *** dv/clkpg_top_asserts.sv ***
// Purpose : Port checker for the clock pulse generator
// Assumes : Mode pins change only while reset is low
// Notes   : Bound to every clkpg_top instance
`timescale 1ns/10ps

module clkpg_top_asserts (
	input wire logic        i_clk_sys,
	input wire logic        i_nrst,
	input wire logic        i_clock_mode_pin_low,
	input wire logic        i_clock_mode_pin_high,
	input wire logic        i_bus_clock_pin,
	input wire logic        i_second_clock_select,
	input wire logic        i_crystal_or_external_clock_input,
	input wire logic        o_crystal_drive_pin,
	input wire logic        o_bus_clock_pin_oe,
	input wire logic        o_second_clock_output_pin,
	input wire logic        o_second_clock_output_pin_oe,
	input wire logic        o_clk_bus_rise,
	input wire logic [3:0]  i_addr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	// ==========================================================
	// Helpers: age hides the strap sync latency after release
	logic [3:0] age_q; // Cycles since release, saturating
	logic       m7;    // Straps select mode seven
	logic       rsv;   // Reserved strap combination
	logic [2:0] mul2;  // Expected stage-two factor
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) age_q <= 4'h0;
		else if (age_q != 4'hF) age_q <= age_q + 4'h1;
	end
	assign m7   = i_clock_mode_pin_high && i_clock_mode_pin_low;
	assign rsv  = !i_clock_mode_pin_high && i_clock_mode_pin_low;
	assign mul2 = !i_clock_mode_pin_high ? clkpg_pkg::MUL2_MODE2 :
		(i_clock_mode_pin_low ? clkpg_pkg::MUL2_OFF : clkpg_pkg::MUL2_MODE6);

	// ==========================================================
	// Assertions
	AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 32'h0)
		else $error("read data not zero outside a read");
	AST_M7_PIN_IN: assert property (m7 |-> !o_bus_clock_pin_oe)
		else $error("bus clock pin driven in mode seven");
	AST_M7_OUT2_Z: assert property (m7 |-> !o_second_clock_output_pin_oe)
		else $error("second clock pin driven in mode seven");
	AST_M7_NO_DRV: assert property (m7 && age_q == 4'hF |-> !o_crystal_drive_pin)
		else $error("oscillator drive active in mode seven");
	// Drive is the inverted reference seen through two sync flops and one output flop
	AST_CRYSTAL_DRIVE_PIN_DRV: assert property (age_q == 4'hF && !m7
		|-> o_crystal_drive_pin == !$past(i_crystal_or_external_clock_input, 3))
		else $error("oscillator drive does not follow the reference");
	AST_OUT2_LOW: assert property (!i_second_clock_select [*3] |-> !o_second_clock_output_pin)
		else $error("second clock pin not low while deselected");
	AST_STAT_MODE: assert property (age_q == 4'hF && i_rd && i_addr == clkpg_pkg::OFF_STAT && !rsv
		|=> o_rdata[1:0] == {i_clock_mode_pin_high, i_clock_mode_pin_low})
		else $error("reported mode differs from straps");
	AST_STAT_MUL2: assert property (age_q == 4'hF && i_rd && i_addr == clkpg_pkg::OFF_STAT
		|=> o_rdata[6:4] == mul2)
		else $error("stage two factor differs from mode");
	AST_FREQ_MASK: assert property (i_rd && i_addr == clkpg_pkg::OFF_FREQ
		|=> (o_rdata & ~{16'h0, clkpg_pkg::FRQ_WMASK}) == 32'h0)
		else $error("unimplemented frequency bits read nonzero");
	AST_M7_FOLLOW: assert property (age_q == 4'hF && m7 && $rose(i_bus_clock_pin)
		|-> ##[1:6] o_clk_bus_rise)
		else $error("bus clock does not follow the pin in mode seven");
	AST_RISE_ONE: assert property (o_clk_bus_rise |=> !o_clk_bus_rise)
		else $error("bus rise pulse longer than one cycle");
endmodule // clkpg_top_asserts

bind clkpg_top clkpg_top_asserts u_chk (.i_clk_sys, .i_nrst, .i_clock_mode_pin_low,
	.i_clock_mode_pin_high, .i_bus_clock_pin, .i_second_clock_select,
	.i_crystal_or_external_clock_input, .o_crystal_drive_pin,
	.o_bus_clock_pin_oe, .o_second_clock_output_pin, .o_second_clock_output_pin_oe,
	.o_clk_bus_rise, .i_addr, .i_rd, .o_rdata);

// *** dv/tb.sv ***
// Purpose : Self-checking bench for the clock pulse generator
// Assumes : Straps change only under reset
// Notes   : Clock activity is counted over fixed 40-cycle windows
`timescale 1ns/10ps

module tb;
	logic        i_clk_sys, i_nrst, plo, phi, sel2, wr, rd, rclk, pin, pdrv, poe, o2, o2oe;
	logic        cir, cpr, cbr, cb, ci;
	logic [7:0]  cm;
	logic [9:0]  sv; // Probes counted by cnt
	logic [3:0]  addr;
	logic [31:0] wd, rdat, v;
	int          miscompares = 0, n_tests = 0, cyc = 0, c = 0, mu = 1;
	logic [1:0]  pins [4] = '{2'b00, 2'b10, 2'b11, 2'b01}; // Modes 2, 6, 7, reserved
	logic [2:0]  m2 [4]   = '{3'h4, 3'h2, 3'h0, 3'h4};
	logic [3:0]  ra [4]   = '{4'h0, 4'h4, 4'h8, 4'h2};      // Last one is unmapped
	logic [31:0] rv [4]   = '{32'h0000_1000, 32'h0, 32'h0, 32'h0};

	// ==========================================================
	// Clock, probes and instances
	initial begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end
	// Bit 6 marks a peripheral rise landing with a bus rise: phase alignment
	assign sv = {pdrv, ci, cb, cbr & cpr, |cm[7:4], |cm[3:0], o2, cbr, cpr, cir};
	clkpg_board u_brd (.i_pin_out(pdrv), .i_pin_oe(poe), .o_ref(rclk), .o_pin(pin));
	clkpg_top dut (.i_clk_sys, .i_nrst, .i_clock_mode_pin_low(plo),
		.i_clock_mode_pin_high(phi), .i_crystal_or_external_clock_input(rclk),
		.o_crystal_drive_pin(), .i_bus_clock_pin(pin), .o_bus_clock_pin(pdrv),
		.o_bus_clock_pin_oe(poe), .i_second_clock_select(sel2),
		.o_second_clock_output_pin(o2), .o_second_clock_output_pin_oe(o2oe),
		.o_clk_int(ci), .o_clk_int_rise(cir), .o_clk_per(), .o_clk_per_rise(cpr),
		.o_clk_bus(cb), .o_clk_bus_rise(cbr), .o_clk_mod(cm), .i_addr(addr),
		.i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat));

	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr32(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge i_clk_sys);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd32(input logic [3:0] a);
		@(posedge i_clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_clk_sys);
		rd <= 1'b0;
		#1 v = rdat;
	endtask
	// Settle past any ratio hand-over, then count high cycles of one probe
	task automatic cnt(input int s);
		c = 0;
		repeat (12) @(posedge i_clk_sys);
		repeat (40) begin
			@(posedge i_clk_sys);
			#1 c += int'(sv[s]);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Hang guard, far above the few thousand cycles the run needs
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 10000) begin
			miscompares++;
			close_out();
		end
	end

	// ==========================================================
	// Main sequence: one pass per strap setting
	initial begin
		i_nrst = 1'b0;
		{plo, phi, sel2, wr, rd} = 5'h0;
		addr = 4'h0;
		wd = 32'h0;
		for (int m = 0; m < 4; m++) begin
			@(posedge i_clk_sys);
			i_nrst <= 1'b0;
			{phi, plo} <= pins[m];
			repeat (10) @(posedge i_clk_sys);
			i_nrst <= 1'b1;
			repeat (12) @(posedge i_clk_sys);
			for (int k = 0; k < 4; k++) begin
				rd32(ra[k]);
				chk("reset value", v, rv[k]);
			end
			rd32(clkpg_pkg::OFF_STAT);
			chk("status", v, {21'h0, 3'h1, 1'b0, m2[m], 1'b1, m == 3,
				(m == 3) ? 2'b00 : pins[m]});
			chk("pin drive", poe, m != 2);
			chk("second drive", o2oe, m != 2);
			// Largest stage-one select; mode two must clamp it, status must refuse writes
			wr32(clkpg_pkg::OFF_FREQ, 32'h0000_1301);
			wr32(clkpg_pkg::OFF_STAT, 32'hFFFF_FFFF);
			rd32(clkpg_pkg::OFF_STAT);
			mu = (m == 0 || m == 3) ? 2 : 4;
			chk("stage one", v[10:8], mu);
			cnt(2);
			chk("bus rises", c, (m == 2) ? 5 : 20 / mu);
			cnt(0);
			chk("int rises", c, 20);
			cnt(1);
			chk("per rises", c, 10);
			cnt(6);
			chk("aligned rises", c, (m == 2) ? 5 : 20 / mu);
			cnt(7);
			chk("bus level", c, 20);
			cnt(8);
			chk("int level", c, 20);
			cnt(9);
			chk("pin level", c, (m == 2) ? 0 : 20);
			if (m != 2) begin
				wr32(clkpg_pkg::OFF_PWR, 32'h1);
				cnt(0);
				chk("sleep int", c, 0);
				cnt(2);
				chk("sleep bus", c, 20 / mu);
				wr32(clkpg_pkg::OFF_PWR, 32'h2);
				cnt(1);
				chk("standby per", c, 0);
				cnt(2);
				chk("standby bus", c, 20 / mu);
				wr32(clkpg_pkg::OFF_FREQ, 32'h0000_0301);
				cnt(2);
				chk("standby quiet", c, 0);
				wr32(clkpg_pkg::OFF_PWR, 32'h4);
				cnt(3);
				chk("second low", c, 0);
				chk("pin float", poe, 1'b0);
				wr32(clkpg_pkg::OFF_PWR, 32'h0);
				wr32(clkpg_pkg::OFF_MSTOP, 32'h0000_000F);
				@(posedge i_clk_sys);
				sel2 <= 1'b1;
				cnt(4);
				chk("stopped modules", c, 0);
				cnt(5);
				chk("running modules", c, 20);
				cnt(3);
				chk("second clock", c, 20);
				@(posedge i_clk_sys);
				sel2 <= 1'b0;
			end
		end
		close_out();
	end
endmodule // tb
